// *** tcm_pkg.sv ***
// Purpose: Shared constants and types for the torque cut-off input monitor.
// Assumes: core_clk at 250 MHz.
// Notes:   Error codes are the numbers reported on the error output.
`default_nettype none
package tcm_pkg;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_MHZ         = 250;
    localparam int TICK_US         = 1000;
    localparam int TICK_CYCLES     = CLK_MHZ * TICK_US;
    localparam int SKEW_MS         = 120;
    localparam int INTERRUPT_MS    = 200;
    localparam int BLOCK_MS        = 50;
    localparam int DIAG_MS         = 630;
    localparam int DIAG_MIN_MS     = 190;
    localparam int DIAG_MAX_MS     = 1480;
    localparam int MIN_TEST_MS     = 1600;
    localparam logic [15:0] DELAY_RESET_MS = 16'h01F4;

    // ****************************************************************
    // Error codes
    // ****************************************************************
    localparam logic [9:0] ERR_NONE         = 10'h000;
    localparam logic [9:0] ERR_REMAINS      = 10'h212;
    localparam logic [9:0] ERR_INTERRUPTION = 10'h213;
    localparam logic [9:0] ERR_MISSING      = 10'h214;
    localparam logic [9:0] ERR_FAULT        = 10'h215;
    localparam logic [9:0] ERR_NO_TRAVEL    = 10'h216;
    localparam logic [9:0] ERR_DIAGNOSTIC   = 10'h3C0;

    typedef struct packed {
        logic       valid;
        logic [9:0] code;
    } tcm_err_t;

    typedef enum logic [1:0] {
        TCM_IDLE,
        TCM_TRAVEL,
        TCM_END
    } tcm_phase_t;
endpackage
`default_nettype wire

// *** tcm_tick.sv ***
// Purpose: Millisecond tick divider.
// Assumes: Synchronous active-high reset.
// Notes:   One-cycle pulse every DIVIDE cycles.
`default_nettype none
module tcm_tick #(
    parameter int DIVIDE = tcm_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic sys_rst,
    // Tick
    output var  logic msTick
);
    logic [31:0] count_r;

    always_ff @(posedge core_clk) begin
        if (sys_rst || count_r == 32'(DIVIDE - 1)) begin
            count_r <= 32'h0000_0000;
        end else begin
            count_r <= count_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge core_clk) begin
        msTick <= !sys_rst && count_r == 32'(DIVIDE - 1);
    end
endmodule
`default_nettype wire

// *** tcm_monitor.sv ***
// Purpose: Supervises the two torque cut-off channels of a lift drive.
// Assumes: Inputs synchronous to core_clk; travel request is a level from the drive control.
`default_nettype none
module tcm_monitor #(
    parameter int TICK_DIVIDE  = tcm_pkg::TICK_CYCLES,
    parameter int SKEW_LIMIT   = tcm_pkg::SKEW_MS,
    parameter int INTR_DELAY   = tcm_pkg::INTERRUPT_MS,
    parameter int DIAG_DELAY   = tcm_pkg::DIAG_MS
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // Cut-off channels and travel request
    input  wire logic        cutoffChannelA,
    input  wire logic        cutoffChannelB,
    input  wire logic        travelRequest,
    // Configuration
    input  wire logic        monitorEnable,
    input  wire logic [15:0] cutoffCheckDelay,
    // Outputs
    output var  logic        torqueEnable,
    output var  logic        safeTorqueCutoff,
    output var  logic        diagLocked,
    output var  tcm_pkg::tcm_err_t errReport
);
    // ****************************************************************
    // Synchronisers and tick
    // ****************************************************************
    logic [1:0] syncA_r, syncB_r;
    logic       chA, chB, msTick;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            syncA_r <= 2'h0;
            syncB_r <= 2'h0;
        end else begin
            syncA_r <= {syncA_r[0], cutoffChannelA};
            syncB_r <= {syncB_r[0], cutoffChannelB};
        end
    end
    assign chA = syncA_r[1];
    assign chB = syncB_r[1];

    tcm_tick #(.DIVIDE(TICK_DIVIDE)) u_tick (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .msTick   (msTick)
    );

    logic bothHigh, bothLow, mismatch;
    assign bothHigh = chA && chB;
    assign bothLow  = !chA && !chB;
    assign mismatch = chA != chB;

    // ****************************************************************
    // Output stage gate
    // ****************************************************************
    // Gated from the synchronised level: the block happens three cycles
    // after a drop, far inside the switch-off budget.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            torqueEnable     <= 1'b0;
            safeTorqueCutoff <= 1'b1;
        end else begin
            torqueEnable     <= bothHigh && !diagLocked;
            safeTorqueCutoff <= !(bothHigh && !diagLocked);
        end
    end

    // ****************************************************************
    // Skew supervision and locked diagnostic
    // ****************************************************************
    logic [15:0] skewMs_r;
    logic        skewFault_r;
    logic [15:0] diagMs_r;
    logic        faultPulse, diagPulse;

    always_ff @(posedge core_clk) begin
        if (sys_rst || !mismatch) begin
            skewMs_r <= 16'h0000;
        end else if (msTick && skewMs_r != 16'hFFFF) begin
            skewMs_r <= skewMs_r + 16'h0001;
        end
    end
    assign faultPulse = mismatch && msTick && skewMs_r == 16'(SKEW_LIMIT);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            skewFault_r <= 1'b0;
        end else if (faultPulse) begin
            skewFault_r <= 1'b1;
        end else if (!mismatch) begin
            skewFault_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst || !skewFault_r) begin
            diagMs_r <= 16'h0000;
        end else if (msTick && diagMs_r != 16'hFFFF) begin
            diagMs_r <= diagMs_r + 16'h0001;
        end
    end
    assign diagPulse = skewFault_r && mismatch && msTick && diagMs_r == 16'(DIAG_DELAY - 1);

    // Only reset clears the lock; nothing software-visible may release it.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            diagLocked <= 1'b0;
        end else if (diagPulse) begin
            diagLocked <= 1'b1;
        end
    end

    // ****************************************************************
    // Per-journey plausibility
    // ****************************************************************
    tcm_pkg::tcm_phase_t phase_r;
    logic        travelPrev_r;
    logic        highPrev_r, lowPrev_r;
    logic [15:0] chkMs_r, intrMs_r;
    logic        chkRun_r, intrRun_r;
    logic        startChk_r, endChk_r, idleChk_r;
    logic        chkDone, intrDone;

    assign chkDone  = chkRun_r && msTick && chkMs_r + 16'h0001 >= cutoffCheckDelay;
    assign intrDone = intrRun_r && msTick && intrMs_r == 16'(INTR_DELAY - 1);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            travelPrev_r <= 1'b0;
            highPrev_r   <= 1'b0;
            lowPrev_r    <= 1'b1;
        end else begin
            travelPrev_r <= travelRequest;
            highPrev_r   <= bothHigh;
            lowPrev_r    <= bothLow;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            phase_r <= tcm_pkg::TCM_IDLE;
        end else begin
            unique case (phase_r)
                tcm_pkg::TCM_IDLE:   if (travelRequest) phase_r <= tcm_pkg::TCM_TRAVEL;
                tcm_pkg::TCM_TRAVEL: if (!travelRequest) phase_r <= tcm_pkg::TCM_END;
                tcm_pkg::TCM_END:    phase_r <= travelRequest ? tcm_pkg::TCM_TRAVEL : tcm_pkg::TCM_IDLE;
                default:             phase_r <= tcm_pkg::TCM_IDLE;
            endcase
        end
    end

    // One shared check timer: journey start, journey end or standstill release.
    always_ff @(posedge core_clk) begin
        if (sys_rst || !monitorEnable) begin
            chkRun_r   <= 1'b0;
            chkMs_r    <= 16'h0000;
            startChk_r <= 1'b0;
            endChk_r   <= 1'b0;
            idleChk_r  <= 1'b0;
        end else if (travelRequest && !travelPrev_r) begin
            chkRun_r   <= 1'b1;
            chkMs_r    <= 16'h0000;
            startChk_r <= 1'b1;
            endChk_r   <= 1'b0;
            idleChk_r  <= 1'b0;
        end else if (!travelRequest && travelPrev_r) begin
            chkRun_r   <= 1'b1;
            chkMs_r    <= 16'h0000;
            startChk_r <= 1'b0;
            endChk_r   <= 1'b1;
            idleChk_r  <= 1'b0;
        end else if (!travelRequest && bothHigh && !highPrev_r && !chkRun_r) begin
            chkRun_r   <= 1'b1;
            chkMs_r    <= 16'h0000;
            startChk_r <= 1'b0;
            endChk_r   <= 1'b0;
            idleChk_r  <= 1'b1;
        end else if (chkDone) begin
            chkRun_r <= 1'b0;
        end else if (chkRun_r && msTick) begin
            chkMs_r <= chkMs_r + 16'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst || !monitorEnable || !travelRequest || !bothLow) begin
            intrRun_r <= 1'b0;
            intrMs_r  <= 16'h0000;
        end else if (phase_r == tcm_pkg::TCM_TRAVEL && !lowPrev_r && !(chkRun_r && startChk_r)) begin
            // A drop while the start check still runs belongs to that check, not to an interruption.
            intrRun_r <= 1'b1;
            intrMs_r  <= 16'h0000;
        end else if (intrRun_r && msTick && intrMs_r != 16'hFFFF) begin
            intrMs_r <= intrMs_r + 16'h0001;
        end
    end

    // ****************************************************************
    // Error report
    // ****************************************************************
    // Diagnostic outranks the fault, which outranks journey checks; the
    // valid pulse is one cycle, the code holds until a newer error.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            errReport <= '{valid: 1'b0, code: tcm_pkg::ERR_NONE};
        end else begin
            errReport.valid <= 1'b0;
            if (diagPulse) begin
                errReport <= '{valid: 1'b1, code: tcm_pkg::ERR_DIAGNOSTIC};
            end else if (faultPulse) begin
                errReport <= '{valid: 1'b1, code: tcm_pkg::ERR_FAULT};
            end else if (intrDone) begin
                errReport <= '{valid: 1'b1, code: tcm_pkg::ERR_INTERRUPTION};
            end else if (chkDone && startChk_r && bothLow && travelRequest) begin
                errReport <= '{valid: 1'b1, code: tcm_pkg::ERR_REMAINS};
            end else if (chkDone && endChk_r && bothHigh && !travelRequest) begin
                errReport <= '{valid: 1'b1, code: tcm_pkg::ERR_MISSING};
            end else if (chkDone && idleChk_r && bothHigh && !travelRequest) begin
                errReport <= '{valid: 1'b1, code: tcm_pkg::ERR_NO_TRAVEL};
            end
        end
    end
    // Journey checks stop while monitorEnable is low, which is how bridged inputs are tolerated.
endmodule
`default_nettype wire

// *** tcm_monitor_props.sv ***
// Purpose: Port assertions for the cut-off monitor.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Latency of three cycles is two sync flops plus one output register.
`default_nettype none
module tcm_monitor_props #(
    parameter int TICK_DIVIDE = 10,
    parameter int SKEW_LIMIT  = 120
) (
    // Clock and reset
    input wire logic              core_clk,
    input wire logic              sys_rst,
    // Watched ports
    input wire logic              cutoffChannelA,
    input wire logic              cutoffChannelB,
    input wire logic              torqueEnable,
    input wire logic              safeTorqueCutoff,
    input wire logic              diagLocked,
    input wire tcm_pkg::tcm_err_t errReport
);
    int misCnt;
    // Counts pin-level mismatch cycles so the skew tolerance can be judged without the tick.
    always_ff @(posedge core_clk) begin
        misCnt <= (sys_rst || cutoffChannelA == cutoffChannelB) ? 0 : misCnt + 1;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    property p_inverse; safeTorqueCutoff == !torqueEnable; endproperty
    a_inverse: assert property (p_inverse) else $error("cutoff output not inverse of torque");
    property p_needBoth; torqueEnable |-> $past(cutoffChannelA, 3) && $past(cutoffChannelB, 3); endproperty
    a_needBoth: assert property (p_needBoth) else $error("torque kept after a channel drop");
    property p_torqueOn; (!sys_rst && cutoffChannelA && cutoffChannelB && !diagLocked) [*4] |-> torqueEnable; endproperty
    a_torqueOn: assert property (p_torqueOn) else $error("torque missing with both channels high");
    property p_lockHold; diagLocked |=> diagLocked; endproperty
    a_lockHold: assert property (p_lockHold) else $error("diagnostic lock released");
    property p_lockOff; diagLocked |=> !torqueEnable; endproperty
    a_lockOff: assert property (p_lockOff) else $error("torque while locked");
    property p_lockCode; errReport.valid && errReport.code == tcm_pkg::ERR_DIAGNOSTIC |-> ##[0:1] diagLocked; endproperty
    a_lockCode: assert property (p_lockCode) else $error("diagnostic error without lock");
    property p_faultSkew;
        errReport.valid && errReport.code == tcm_pkg::ERR_FAULT |-> $past(misCnt, 3) >= SKEW_LIMIT * TICK_DIVIDE;
    endproperty
    a_faultSkew: assert property (p_faultSkew) else $error("fault raised inside skew tolerance");
    property p_pulse; errReport.valid |=> !errReport.valid [*8]; endproperty
    a_pulse: assert property (p_pulse) else $error("error valid off the tick grid");
    property p_codeHeld; $changed(errReport.code) |-> errReport.valid; endproperty
    a_codeHeld: assert property (p_codeHeld) else $error("error code changed without valid");
    c_interrupt: cover property (errReport.valid && errReport.code == tcm_pkg::ERR_INTERRUPTION);
    c_fault: cover property (errReport.valid && errReport.code == tcm_pkg::ERR_FAULT);
    c_lock: cover property ($rose(diagLocked));
endmodule
bind tcm_monitor tcm_monitor_props #(.TICK_DIVIDE(TICK_DIVIDE), .SKEW_LIMIT(SKEW_LIMIT)) i_props (
    .core_clk(core_clk), .sys_rst(sys_rst), .cutoffChannelA(cutoffChannelA), .cutoffChannelB(cutoffChannelB),
    .torqueEnable(torqueEnable), .safeTorqueCutoff(safeTorqueCutoff), .diagLocked(diagLocked),
    .errReport(errReport));
`default_nettype wire

// *** tcm_lift_model.sv ***
// Purpose: Lift controller relays driving both cut-off channels.
// Assumes: Commands change just after a rising edge.
// Notes:   Channel B lags by skewCyc cycles on every switch, a sticky relay when large.
`default_nettype none
module tcm_lift_model (
    // Clock and relay command
    input  wire logic        core_clk,
    input  wire logic        relayOn,
    input  wire logic [15:0] skewCyc,
    // Cut-off channels
    output var  logic        chanA,
    output var  logic        chanB
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] lagCnt = 16'h0000;
    initial chanA = 1'b0;
    initial chanB = 1'b0;
    // Both relays follow one command, so the skew stays in tolerance unless a scenario asks otherwise.
    always @(posedge core_clk) begin
        chanA <= relayOn;
        if (chanB == relayOn) lagCnt <= 16'h0000;
        else if (lagCnt >= skewCyc) chanB <= relayOn;
        else lagCnt <= lagCnt + 16'h0001;
    end
endmodule
`default_nettype wire

// *** tcm_monitor_bench.sv ***
// Purpose: Self-checking bench for the cut-off monitor.
// Assumes: Tick shortened to ten cycles.
// Notes:   Error pulses are recorded on the falling edge to avoid races.
`default_nettype none
module tcm_monitor_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DIV = 10;
    logic core_clk = 1'b0, sys_rst = 1'b1, relayOn = 1'b0, travelRequest = 1'b0, monitorEnable = 1'b1;
    logic chanA, chanB, torqueEnable, safeTorqueCutoff, diagLocked;
    logic [15:0] skewCyc = 16'h0000;
    logic [15:0] chkDelay = 16'h0005;
    logic [9:0] lastCode = 10'h000;
    tcm_pkg::tcm_err_t errReport;
    int nErr = 0, n_fail = 0, checked = 0;
    always #2 core_clk = ~core_clk;
    tcm_lift_model i_lift (.core_clk(core_clk), .relayOn(relayOn), .skewCyc(skewCyc), .chanA(chanA), .chanB(chanB));
    tcm_monitor #(.TICK_DIVIDE(DIV)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .cutoffChannelA(chanA),
        .cutoffChannelB(chanB), .travelRequest(travelRequest), .monitorEnable(monitorEnable),
        .cutoffCheckDelay(chkDelay), .torqueEnable(torqueEnable), .safeTorqueCutoff(safeTorqueCutoff),
        .diagLocked(diagLocked), .errReport(errReport));
    always @(negedge core_clk) begin
        if (errReport.valid === 1'b1) begin
            lastCode = errReport.code;
            nErr = nErr + 1;
        end
    end
    task automatic report_and_stop();
        if (n_fail == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n * DIV) @(posedge core_clk);
    endtask
    task automatic setIn(input logic relay, input logic travel);
        @(posedge core_clk);
        relayOn <= relay;
        travelRequest <= travel;
    endtask
    task automatic quiet(input int n);
        int base;
        base = nErr;
        ticks(n);
        chk(16'(nErr - base), 16'h0000);
    endtask
    // Errors land on tick boundaries, so the window allows two ticks of phase either side.
    task automatic expectErr(input logic [9:0] code, input int nominal);
        int base;
        int i;
        base = nErr;
        ticks(nominal - 2);
        chk(16'(nErr - base), 16'h0000);
        for (i = 0; i < 4 * DIV && nErr == base; i++) @(posedge core_clk);
        chk(16'(nErr - base), 16'h0001);
        chk({6'h00, lastCode}, {6'h00, code});
        if (nErr == base) report_and_stop();
    endtask
    task automatic s_interrupt();
        setIn(1'b0, 1'b1);
        ticks(2);
        setIn(1'b1, 1'b1);
        quiet(8);
        chk({15'h0000, torqueEnable}, 16'h0001);
        setIn(1'b0, 1'b1);
        repeat (5) @(posedge core_clk);
        chk({15'h0000, torqueEnable}, 16'h0000);
        chk({15'h0000, safeTorqueCutoff}, 16'h0001);
        expectErr(tcm_pkg::ERR_INTERRUPTION, tcm_pkg::INTERRUPT_MS);
        setIn(1'b0, 1'b0);
        quiet(10);
    endtask
    task automatic s_journeys();
        setIn(1'b0, 1'b1);
        expectErr(tcm_pkg::ERR_REMAINS, 5);
        setIn(1'b1, 1'b1);
        quiet(8);
        setIn(1'b1, 1'b0);
        expectErr(tcm_pkg::ERR_MISSING, 5);
        setIn(1'b0, 1'b0);
        quiet(10);
        setIn(1'b1, 1'b0);
        expectErr(tcm_pkg::ERR_NO_TRAVEL, 5);
        setIn(1'b0, 1'b0);
        quiet(10);
        chkDelay <= 16'h0003;
        setIn(1'b1, 1'b0);
        expectErr(tcm_pkg::ERR_NO_TRAVEL, 3);
        setIn(1'b0, 1'b0);
        quiet(10);
        chkDelay <= 16'h0005;
    endtask
    task automatic s_skew();
        monitorEnable <= 1'b0;
        setIn(1'b1, 1'b0);
        quiet(20);
        skewCyc <= 16'(115 * DIV);
        setIn(1'b0, 1'b0);
        ticks(50);
        chk({15'h0000, torqueEnable}, 16'h0000);
        quiet(80);
        setIn(1'b1, 1'b0);
        quiet(130);
        skewCyc <= 16'hFFFF;
        setIn(1'b0, 1'b0);
        expectErr(tcm_pkg::ERR_FAULT, tcm_pkg::SKEW_MS + 1);
        expectErr(tcm_pkg::ERR_DIAGNOSTIC, tcm_pkg::DIAG_MS);
        skewCyc <= 16'h0000;
        setIn(1'b1, 1'b0);
        ticks(10);
        chk({14'h0000, diagLocked, torqueEnable}, 16'h0002);
        sys_rst <= 1'b1;
        ticks(2);
        sys_rst <= 1'b0;
        chk({15'h0000, diagLocked}, 16'h0000);
        ticks(1);
        chk({14'h0000, safeTorqueCutoff, torqueEnable}, 16'h0001);
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        ticks(tcm_pkg::MIN_TEST_MS);
        s_interrupt();
        s_journeys();
        s_skew();
        report_and_stop();
    end
endmodule
`default_nettype wire
